//--- bench/lsrc_chan_model.sv
// Model of the two replicated channels at the three checkpoints.
`include "lsrc_cfg.svh"
module lsrc_chan_model (
	input wire logic clk_sys_i,
	input wire logic [2:0] bad_i,
	output logic [`LSRC_PORT_W-1:0] ch0_o [3],
	output logic [`LSRC_PORT_W-1:0] ch1_o [3]
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [`LSRC_PORT_W-1:0] w;
	initial begin
		ch0_o = '{default: '0};
		ch1_o = '{default: '0};
	end
	always @(posedge clk_sys_i) begin
		for (int k = 0; k < 3; k++) begin
			w = 100'({$urandom, $urandom, $urandom, $urandom});
			ch0_o[k] <= w;
			ch1_o[k] <= bad_i[k] ? w ^ (100'h1 << ($urandom % 100)) : w;
		end
	end
endmodule : lsrc_chan_model

//--- bench/lsrc_top_tb.sv
// Self-checking bench of the lock-step redundancy checker.
`include "lsrc_cfg.svh"
module lsrc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic por_rst_i = 1'b1;
	logic strap = 1'b0;
	logic on = 1'b0;
	logic [2:0] bad = 3'h0;
	logic [`LSRC_PORT_W-1:0] c0 [3];
	logic [`LSRC_PORT_W-1:0] c1 [3];
	logic lock, deco, flt;
	logic [2:0] pt, sty, d, ns;
	logic [2:0] exp_p = 3'h0;
	logic [2:0] exp_s = 3'h0;
	int mismatches = 0;
	int cmp_count = 0;
	always #4 clk_sys_i = ~clk_sys_i;
	lsrc_chan_model u_chan (.clk_sys_i(clk_sys_i), .bad_i(bad), .ch0_o(c0),
		.ch1_o(c1));
	lsrc_top u_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
		.por_rst_i(por_rst_i), .decoupled_strap_i(strap),
		.ch0_periph_i(c0[0]), .ch1_periph_i(c1[0]), .ch0_flash_i(c0[1]),
		.ch1_flash_i(c1[1]), .ch0_sram_i(c0[2]), .ch1_sram_i(c1[2]),
		.lock_step_config_o(lock), .decoupled_parallel_config_o(deco),
		.fault_o(flt), .fault_point_o(pt), .fault_sticky_o(sty));
	task automatic chk(string nm, logic [2:0] e, logic [2:0] g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic give_verdict();
		if (mismatches == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : give_verdict
	always @(posedge clk_sys_i) begin
		if (on) begin
			chk("fault_point", exp_p, pt);
			chk("fault_sticky", exp_s, sty);
			chk("fault", {2'h0, |exp_p}, {2'h0, flt});
		end
		for (int k = 0; k < 3; k++) d[k] = lock & (c0[k] != c1[k]);
		ns = exp_s | exp_p;
		exp_p = (sys_rst_i | por_rst_i) ? 3'h0 : d;
		exp_s = (sys_rst_i | por_rst_i) ? 3'h0 : ns;
	end
	task automatic run(int n);
		repeat (n) begin
			@(posedge clk_sys_i);
			bad <= ($urandom % 4 == 0) ? 3'($urandom) : 3'h0;
		end
	endtask : run
	task automatic power_up(logic s);
		@(posedge clk_sys_i);
		strap <= s;
		por_rst_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		#1 chk("mode_rst", 3'h0, {1'b0, lock, deco});
		@(posedge clk_sys_i);
		por_rst_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		#1 chk("mode_wait", 3'h0, {1'b0, lock, deco});
		@(posedge clk_sys_i);
		#1 chk("mode", {1'b0, ~s, s}, {1'b0, lock, deco});
		@(posedge clk_sys_i);
		strap <= ~s;
		run(200);
		@(posedge clk_sys_i);
		sys_rst_i <= 1'b1;
		@(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		run(200);
		#1 chk("mode_kept", {1'b0, ~s, s}, {1'b0, lock, deco});
	endtask : power_up
	initial begin
		void'($urandom(32'hf7c0));
		repeat (4) @(posedge clk_sys_i);
		on <= 1'b1;
		sys_rst_i <= 1'b0;
		power_up(1'b0);
		power_up(1'b1);
		power_up(1'b0);
		give_verdict();
	end
	initial begin
		#40000;
		mismatches++;
		give_verdict();
	end
endmodule : lsrc_top_tb

//--- hdl/lsrc_cfg.svh
// Constants of the lock-step redundancy checker.
`ifndef LSRC_CFG_SVH
`define LSRC_CFG_SVH
`define LSRC_PORT_W 100
`define LSRC_NUM_PT 3
`define LSRC_PT_PERIPH 0
`define LSRC_PT_FLASH 1
`define LSRC_PT_SRAM 2
`define LSRC_NUM_SRC 3
`define LSRC_SRC_CORE 0
`define LSRC_SRC_DMA 1
`define LSRC_SRC_XBAR 2
`define LSRC_BOOT_WAIT 2'h2
`endif

//--- hdl/lsrc_cmp.sv
// One output checker comparing a channel pair.
`include "lsrc_cfg.svh"
module lsrc_cmp (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic enable_i,
	input wire logic [`LSRC_PORT_W-1:0] chan_a_i,
	input wire logic [`LSRC_PORT_W-1:0] chan_b_i,
	output logic mismatch_o
);
	logic mismatch_q;
	wire differ = (chan_a_i != chan_b_i);
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			mismatch_q <= 1'b0;
		end else begin
			mismatch_q <= enable_i & differ;
		end
	end
	assign mismatch_o = mismatch_q;
endmodule : lsrc_cmp

//--- hdl/lsrc_pkg.sv
// Types of the lock-step redundancy checker.
package lsrc_pkg;
	typedef enum logic [2:0] {
		LSRC_ST_BOOT = 3'h1,
		LSRC_ST_LOCK = 3'h2,
		LSRC_ST_DECO = 3'h4
	} lsrc_state_type;
endpackage : lsrc_pkg

//--- hdl/lsrc_top.sv
// Mode control and output comparison of the dual-channel platform.
`include "lsrc_cfg.svh"
module lsrc_top
	import lsrc_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic por_rst_i,
	input wire logic decoupled_strap_i,
	input wire logic [`LSRC_PORT_W-1:0] ch0_periph_i,
	input wire logic [`LSRC_PORT_W-1:0] ch1_periph_i,
	input wire logic [`LSRC_PORT_W-1:0] ch0_flash_i,
	input wire logic [`LSRC_PORT_W-1:0] ch1_flash_i,
	input wire logic [`LSRC_PORT_W-1:0] ch0_sram_i,
	input wire logic [`LSRC_PORT_W-1:0] ch1_sram_i,
	output logic lock_step_config_o,
	output logic decoupled_parallel_config_o,
	output logic fault_o,
	output logic [`LSRC_NUM_PT-1:0] fault_point_o,
	output logic [`LSRC_NUM_PT-1:0] fault_sticky_o
);
	// ********************
	// Configuration choice
	// ********************
	lsrc_state_type state_q;
	lsrc_state_type state_d;
	logic strap_s1_q;
	logic strap_s2_q;
	logic [`LSRC_NUM_PT-1:0] sticky_q;
	logic [1:0] boot_cnt_q;
	logic [1:0] boot_cnt_d;
	wire boot_done = (boot_cnt_q == `LSRC_BOOT_WAIT);
	wire any_rst = sys_rst_i | por_rst_i;
	wire checks_on = (state_q == LSRC_ST_LOCK);
	always_ff @(posedge clk_sys_i) begin
		if (por_rst_i) begin
			strap_s1_q <= 1'b0;
			strap_s2_q <= 1'b0;
		end else begin
			strap_s1_q <= decoupled_strap_i;
			strap_s2_q <= strap_s1_q;
		end
	end
	// ********************
	// Boot wait
	// ********************
	// Waits until the strap has passed both synchroniser stages.
	assign boot_cnt_d = boot_done ? boot_cnt_q : boot_cnt_q + 2'h1;
	always_ff @(posedge clk_sys_i) begin
		if (por_rst_i) begin
			boot_cnt_q <= 2'h0;
		end else begin
			boot_cnt_q <= boot_cnt_d;
		end
	end
	// ********************
	// Mode decision
	// ********************
	// Maps the synchronised strap level onto the chosen configuration.
	function automatic lsrc_state_type pick_mode(input logic strap);
		pick_mode = strap ? LSRC_ST_DECO : LSRC_ST_LOCK;
	endfunction : pick_mode
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			LSRC_ST_BOOT: state_d = boot_done ? pick_mode(strap_s2_q)
				: LSRC_ST_BOOT;
			LSRC_ST_LOCK: state_d = LSRC_ST_LOCK;
			LSRC_ST_DECO: state_d = LSRC_ST_DECO;
			default: state_d = LSRC_ST_BOOT;
		endcase
	end
	// Only power-on reset touches the choice; sys_rst_i does not.
	always_ff @(posedge clk_sys_i) begin
		if (por_rst_i) begin
			state_q <= LSRC_ST_BOOT;
		end else begin
			state_q <= state_d;
		end
	end
	assign lock_step_config_o = checks_on;
	assign decoupled_parallel_config_o = (state_q == LSRC_ST_DECO);
	// ********************
	// Output checkers
	// ********************
	// Core, DMA and crossbar traffic all leaves through these three ports.
	logic [`LSRC_NUM_PT-1:0] mis;
	lsrc_cmp u_cmp_periph (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(any_rst),
		.enable_i(checks_on),
		.chan_a_i(ch0_periph_i),
		.chan_b_i(ch1_periph_i),
		.mismatch_o(mis[`LSRC_PT_PERIPH])
	);
	lsrc_cmp u_cmp_flash (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(any_rst),
		.enable_i(checks_on),
		.chan_a_i(ch0_flash_i),
		.chan_b_i(ch1_flash_i),
		.mismatch_o(mis[`LSRC_PT_FLASH])
	);
	lsrc_cmp u_cmp_sram (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(any_rst),
		.enable_i(checks_on),
		.chan_a_i(ch0_sram_i),
		.chan_b_i(ch1_sram_i),
		.mismatch_o(mis[`LSRC_PT_SRAM])
	);
	// ********************
	// Fault reporting
	// ********************
	always_ff @(posedge clk_sys_i) begin
		if (any_rst) begin
			sticky_q <= '0;
		end else begin
			sticky_q <= sticky_q | mis;
		end
	end
	assign fault_point_o = mis;
	assign fault_o = |mis;
	assign fault_sticky_o = sticky_q;
	// ********************
	// Assertions
	// ********************
	AST_MODE_FROZEN: assert property (
		@(posedge clk_sys_i) disable iff (por_rst_i)
		(state_q != LSRC_ST_BOOT) |=> $stable(state_q))
		else $error("configuration changed without power-on reset");
	AST_SYSRST_KEEPS: assert property (
		@(posedge clk_sys_i) disable iff (por_rst_i)
		(sys_rst_i && state_q == LSRC_ST_LOCK) |=> state_q == LSRC_ST_LOCK)
		else $error("system reset altered configuration");
	AST_CHECK_PERIPH: assert property (@(posedge clk_sys_i)
		disable iff (sys_rst_i | por_rst_i)
		(checks_on && ch0_periph_i != ch1_periph_i)
		|=> fault_point_o[`LSRC_PT_PERIPH])
		else $error("peripheral mismatch not flagged");
	AST_CHECK_FLASH: assert property (@(posedge clk_sys_i)
		disable iff (sys_rst_i | por_rst_i)
		(checks_on && ch0_flash_i != ch1_flash_i)
		|=> fault_point_o[`LSRC_PT_FLASH])
		else $error("flash mismatch not flagged");
	AST_CHECK_SRAM: assert property (@(posedge clk_sys_i)
		disable iff (sys_rst_i | por_rst_i)
		(checks_on && ch0_sram_i != ch1_sram_i)
		|=> fault_point_o[`LSRC_PT_SRAM])
		else $error("sram mismatch not flagged");
	AST_DECO_QUIET: assert property (@(posedge clk_sys_i)
		disable iff (sys_rst_i | por_rst_i)
		(state_q == LSRC_ST_DECO) [*2] |-> !fault_o)
		else $error("fault raised in decoupled configuration");
	AST_NO_FALSE: assert property (@(posedge clk_sys_i)
		disable iff (sys_rst_i | por_rst_i)
		(ch0_periph_i == ch1_periph_i && ch0_flash_i == ch1_flash_i
		&& ch0_sram_i == ch1_sram_i) |=> !fault_o)
		else $error("fault raised without mismatch");
	AST_STICKY: assert property (@(posedge clk_sys_i)
		disable iff (sys_rst_i | por_rst_i)
		fault_o |=> fault_sticky_o == ($past(fault_sticky_o) | $past(mis)))
		else $error("fault not latched");
	AST_BOOT_HOLD: assert property (@(posedge clk_sys_i)
		disable iff (por_rst_i)
		(state_q == LSRC_ST_BOOT && !boot_done) |=> state_q == LSRC_ST_BOOT)
		else $error("configuration chosen before strap settled");
	AST_MODE_PICK: assert property (@(posedge clk_sys_i)
		disable iff (por_rst_i)
		(state_q == LSRC_ST_BOOT && boot_done)
		|=> decoupled_parallel_config_o == $past(strap_s2_q))
		else $error("configuration does not follow strap");
	AST_ONE_MODE: assert property (@(posedge clk_sys_i)
		!(lock_step_config_o && decoupled_parallel_config_o))
		else $error("both configurations active");
	AST_POR_CLEARS: assert property (@(posedge clk_sys_i)
		por_rst_i |=> (fault_sticky_o == '0 && fault_point_o == '0
		&& !lock_step_config_o && !decoupled_parallel_config_o))
		else $error("power-on reset left state behind");
	AST_DECO_KEEPS: assert property (@(posedge clk_sys_i)
		disable iff (por_rst_i)
		(sys_rst_i && state_q == LSRC_ST_DECO) |=> state_q == LSRC_ST_DECO)
		else $error("system reset altered decoupled configuration");
	AST_SYSRST_CLEARS: assert property (@(posedge clk_sys_i)
		sys_rst_i |=> (fault_sticky_o == '0 && fault_point_o == '0))
		else $error("system reset left faults behind");
	AST_STICKY_HOLD: assert property (@(posedge clk_sys_i)
		disable iff (sys_rst_i | por_rst_i)
		1'b1 |=> (fault_sticky_o & $past(fault_sticky_o))
		== $past(fault_sticky_o))
		else $error("latched fault lost");
	AST_DECO_CLEAN: assert property (@(posedge clk_sys_i)
		disable iff (sys_rst_i | por_rst_i)
		(state_q == LSRC_ST_DECO) [*2] |-> fault_sticky_o == '0)
		else $error("fault latched in decoupled configuration");
	AST_BOOT_QUIET: assert property (@(posedge clk_sys_i)
		disable iff (sys_rst_i | por_rst_i)
		(state_q == LSRC_ST_BOOT) |=> !fault_o)
		else $error("fault raised before configuration chosen");
	AST_ANY_FLAG: assert property (@(posedge clk_sys_i)
		disable iff (sys_rst_i | por_rst_i)
		(checks_on && (ch0_periph_i != ch1_periph_i
		|| ch0_flash_i != ch1_flash_i || ch0_sram_i != ch1_sram_i))
		|=> fault_o)
		else $error("mismatch did not raise fault");
endmodule : lsrc_top
